// file: logic/amx_exec.sv
// alternate-mode shift, skip, indirect i/o, switch read and trap execution with axi4-lite registers
// Overview of operation
// - zero shift count does nothing, next fetch
// - nonzero count sets sync, then repeat flag
// - count field bits 08-11 count down
// - 030 rotates acc:mq right, optional link
// - 034 scales right keeping acc bit 0
// - 024 rotates acc left, optional link
// - skip flag set on condition xor bit07
// - 040 tests selected external level
// - 044 tests sense switch 00-05
// - 0456 skip condition always true
// - 0451 skips when acc positive
// - 0450 skips on acc zero or all ones
// - 0452 skips when link zero
// - 0454 skips when overflow set
// - indirect io runs one following word
// - three i/o pulses gated by word bits
// - strobe, end, restart delays per i/o state
// - after third pulse clear wait, fetch
// - 0516/0517 load acc from switches
// - interrupt vector 0040, or 0140 trapping
// - trap listed opcode ranges when enabled
// - two-word trapped opcodes advance return twice
// - break and interrupt priority over fetch
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`include "amx_regs.svh"
`default_nettype none
module amx_exec
  import amx_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // axi4-lite slave
  input wire logic [5:0] i_awaddr,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [5:0] i_araddr,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  // machine inputs
  input wire logic [11:0] i_ext_level,
  input wire logic [5:0] i_sense_sw,
  input wire logic [11:0] i_right_sw,
  input wire logic [11:0] i_left_sw,
  // i/o bus
  output logic [2:0] o_io_pulse,
  output logic o_io_strobe,
  output logic [11:0] o_io_opcode,
  output logic o_io_wait_flag,
  // status
  output logic [3:0] o_major,
  output logic o_skip
);
  amx_state_e state_reg, state_next;
  logic [7:0] ctrl_reg;
  logic [11:0] instr_reg, oper_reg, acc_reg, mq_reg, ma_reg, ret_reg;
  logic link_reg, flow_reg, skip_reg, sync_reg, repeat_reg, trapped_reg;
  logic [3:0] major_reg;
  logic [7:0] tmr_reg;
  logic [1:0] io_idx_reg;
  logic [1:0] io_phase_reg;
  amx_io_s io_reg;
  logic aw_hold_reg, w_hold_reg;
  logic [5:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  // decoding by opcode family, the seven bits above the indirect bit
  function automatic logic op_is(input logic [11:0] ir, input logic [6:0] hi);
    op_is = (ir[11:5] == hi);
  endfunction : op_is

  wire [3:0] count_w = instr_reg[3:0];
  wire ibit_w = instr_reg[4];
  wire is_rol_w = op_is(instr_reg, 7'h05);
  wire is_ror_w = op_is(instr_reg, 7'h06);
  wire is_scr_w = op_is(instr_reg, 7'h07);
  wire is_shift_w = is_rol_w || is_ror_w || is_scr_w;
  wire is_sxl_w = op_is(instr_reg, 7'h08);
  wire is_skg_w = op_is(instr_reg, 7'h09);
  wire is_skip_w = is_sxl_w || is_skg_w;
  wire is_iob_w = op_is(instr_reg, 7'h0A) && (count_w == 4'h0);
  wire is_rsw_w = (instr_reg == 12'h14E);
  wire is_lsw_w = (instr_reg == 12'h14F);

  // skip condition select
  logic cond_w;
  always_comb begin
    cond_w = 1'b0;
    if (is_sxl_w) begin
      cond_w = i_ext_level[count_w];
    end else if (count_w <= 4'h5) begin
      cond_w = i_sense_sw[count_w[2:0]];
    end else begin
      case (count_w)
        4'hE: cond_w = 1'b1;
        4'h9: cond_w = !acc_reg[11];
        4'h8: cond_w = (acc_reg == 12'h000) || (acc_reg == 12'hFFF);
        4'hA: cond_w = !link_reg;
        4'hC: cond_w = flow_reg;
        4'hD: cond_w = !mq_reg[0];
        default: cond_w = 1'b0;
      endcase
    end
  end
  wire skip_set_w = is_skip_w && (cond_w ^ ibit_w);

  // trappable ranges, bit 0 of the word is the left-most machine bit
  wire in_opr_w = (instr_reg >= 12'h141 && instr_reg <= 12'h14D) || (instr_reg >= 12'h151 && instr_reg <= 12'h15D);
  wire in_undef_w = (instr_reg >= 12'h160 && instr_reg <= 12'h17F) || (instr_reg >= 12'h3C0 && instr_reg <= 12'h3DF);
  wire in_exec_w = (instr_reg >= 12'h1E0 && instr_reg <= 12'h1FF);
  wire in_tape_w = (instr_reg >= 12'h1C0 && instr_reg <= 12'h1DF) && ctrl_reg[`AMX_CTRL_TAPE_TRAP];
  wire trap_hit_w = ctrl_reg[`AMX_CTRL_TRAP] && (in_opr_w || in_undef_w || in_exec_w || in_tape_w);
  wire two_word_w = (instr_reg == 12'h3C0) || (instr_reg == 12'h3D0);

  // one-place shift datapath
  logic [11:0] acc_sh, mq_sh;
  logic link_sh;
  always_comb begin
    acc_sh = acc_reg;
    mq_sh = mq_reg;
    link_sh = link_reg;
    if (is_ror_w) begin
      acc_sh = {ibit_w ? link_reg : mq_reg[0], acc_reg[11:1]};
      mq_sh = {acc_reg[0], mq_reg[11:1]};
      if (ibit_w) begin
        link_sh = mq_reg[0];
      end
    end else if (is_scr_w) begin
      acc_sh = {acc_reg[11], acc_reg[11:1]};
      mq_sh = {acc_reg[0], mq_reg[11:1]};
      if (ibit_w) begin
        link_sh = acc_reg[0];
      end
    end else if (is_rol_w) begin
      acc_sh = {acc_reg[10:0], ibit_w ? link_reg : acc_reg[11]};
      if (ibit_w) begin
        link_sh = acc_reg[11];
      end
    end
  end

  // major state priority at entry
  wire [3:0] major_w = ctrl_reg[`AMX_CTRL_TAPE_BRK] ? AMX_MS_TAPE :
                       ctrl_reg[`AMX_CTRL_DATA_BRK] ? AMX_MS_DATA :
                       ctrl_reg[`AMX_CTRL_INT_REQ] ? AMX_MS_INT : AMX_MS_FETCH;

  wire go_w = ctrl_reg[`AMX_CTRL_GO];
  wire tmr_done_w = (tmr_reg == 8'h00);
  // length of the phase that follows the one now ending
  wire [7:0] phase_len_w = (io_phase_reg == 2'h0) ? 8'(`AMX_END_CYC) :
                           (io_phase_reg == 2'h1) ? 8'(`AMX_RESTART_CYC) : 8'(`AMX_STROBE_CYC);
  wire wr_fire_w = aw_hold_reg && w_hold_reg && !o_bvalid;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      AMX_IDLE: if (go_w) state_next = AMX_DECODE;
      AMX_DECODE: begin
        if (trap_hit_w || is_skip_w || is_rsw_w || is_lsw_w) state_next = AMX_FETCH;
        else if (is_shift_w && count_w != 4'h0) state_next = AMX_SYNC;
        else if (is_iob_w) state_next = AMX_IO;
        else state_next = AMX_FETCH;
      end
      AMX_SYNC: if (tmr_done_w) state_next = AMX_RECYCLE;
      AMX_RECYCLE: if (count_w == 4'h1) state_next = AMX_FETCH;
      AMX_IO: if (tmr_done_w && io_phase_reg == 2'h2 && io_idx_reg == 2'h2) state_next = AMX_FETCH;
      AMX_FETCH: state_next = AMX_IDLE;
      default: state_next = AMX_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= AMX_IDLE;
      instr_reg <= 12'h000;
      acc_reg <= 12'h000;
      mq_reg <= 12'h000;
      link_reg <= 1'b0;
      flow_reg <= 1'b0;
      skip_reg <= 1'b0;
      sync_reg <= 1'b0;
      repeat_reg <= 1'b0;
      ma_reg <= 12'h000;
      ret_reg <= 12'h000;
      trapped_reg <= 1'b0;
      major_reg <= AMX_MS_FETCH;
      tmr_reg <= 8'h00;
      io_idx_reg <= 2'h0;
      io_phase_reg <= 2'h0;
      io_reg <= '0;
      o_io_wait_flag <= 1'b0;
    end else begin
      state_reg <= state_next;
      tmr_reg <= tmr_done_w ? 8'h00 : tmr_reg - 8'h01;
      io_reg.strobe <= 1'b0;
      if (state_reg == AMX_DECODE) begin
        skip_reg <= skip_set_w;
        trapped_reg <= trap_hit_w;
        if (trap_hit_w) begin
          ma_reg <= `AMX_TRAP_VEC;
          ret_reg <= ma_reg + (two_word_w ? 12'h002 : 12'h001);
        end
        if (is_rsw_w) acc_reg <= i_right_sw;
        if (is_lsw_w) acc_reg <= i_left_sw;
        if (is_shift_w && count_w != 4'h0) begin
          sync_reg <= 1'b1;
          tmr_reg <= 8'(`AMX_SYNC_CYC - 1);
        end
        if (is_iob_w && !trap_hit_w && !is_skip_w) begin
          o_io_wait_flag <= 1'b1;
          io_reg.opcode <= oper_reg;
          io_reg.pulse <= {1'b0, 1'b0, oper_reg[0]};
          io_idx_reg <= 2'h0;
          io_phase_reg <= 2'h0;
          tmr_reg <= 8'(`AMX_STROBE_CYC - 1);
        end
      end
      if (state_reg == AMX_SYNC && tmr_done_w) repeat_reg <= sync_reg;
      if (state_reg == AMX_RECYCLE) begin
        acc_reg <= acc_sh;
        mq_reg <= mq_sh;
        link_reg <= link_sh;
        instr_reg[3:0] <= count_w - 4'h1;
        if (count_w == 4'h1) begin
          sync_reg <= 1'b0;
          repeat_reg <= 1'b0;
        end
      end
      if (state_reg == AMX_IO && tmr_done_w) begin
        io_phase_reg <= (io_phase_reg == 2'h2) ? 2'h0 : io_phase_reg + 2'h1;
        tmr_reg <= phase_len_w - 8'h01;
        if (io_phase_reg == 2'h0) io_reg.strobe <= 1'b1;
        if (io_phase_reg == 2'h1) io_reg.pulse <= 3'h0;
        if (io_phase_reg == 2'h2) begin
          if (io_idx_reg == 2'h2) begin
            o_io_wait_flag <= 1'b0;
          end else begin
            io_idx_reg <= io_idx_reg + 2'h1;
            io_reg.pulse <= (io_idx_reg == 2'h0) ? {1'b0, io_reg.opcode[1], 1'b0} : {io_reg.opcode[2], 2'b00};
          end
        end
      end
      if (state_reg == AMX_FETCH) begin
        major_reg <= major_w;
        if (major_w == AMX_MS_INT) ma_reg <= ctrl_reg[`AMX_CTRL_TRAP] ? `AMX_TRAP_VEC : `AMX_INT_VEC;
        else if (!trapped_reg) ma_reg <= ma_reg + (skip_reg ? 12'h002 : 12'h001);
      end
      // software loads of machine registers
      if (wr_fire_w && aw_addr_reg == `AMX_INSTR_ADDR) instr_reg <= w_data_reg[11:0];
      if (wr_fire_w && aw_addr_reg == `AMX_ACC_ADDR) acc_reg <= w_data_reg[11:0];
      if (wr_fire_w && aw_addr_reg == `AMX_MQ_ADDR) mq_reg <= w_data_reg[11:0];
      if (wr_fire_w && aw_addr_reg == `AMX_CTRL_ADDR) begin
        link_reg <= w_data_reg[`AMX_CTRL_LINK];
        flow_reg <= w_data_reg[`AMX_CTRL_FLOW];
      end
    end
  end

  // axi4-lite write path: address and data taken in either order
  assign o_awready = !aw_hold_reg;
  assign o_wready = !w_hold_reg;
  assign o_arready = !o_rvalid;
  wire wr_map_w = (aw_addr_reg[5:2] <= 4'h7);
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 6'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      o_bvalid <= 1'b0;
      o_bresp <= 2'h0;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= 2'h0;
      ctrl_reg <= `AMX_CTRL_RESET;
      oper_reg <= 12'h000;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= i_wdata;
        w_strb_reg <= i_wstrb;
      end
      if (state_reg == AMX_DECODE) ctrl_reg[`AMX_CTRL_GO] <= 1'b0;
      if (wr_fire_w) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_map_w ? 2'h0 : 2'h2;
        if (aw_addr_reg == `AMX_CTRL_ADDR && w_strb_reg[0]) ctrl_reg <= w_data_reg[7:0];
        if (aw_addr_reg == `AMX_OPER_ADDR) oper_reg <= w_data_reg[11:0];
      end else if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
      end
      if (i_arvalid && o_arready) begin
        o_rvalid <= 1'b1;
        o_rresp <= (i_araddr[5:2] <= 4'h7) ? 2'h0 : 2'h2;
        unique case (i_araddr[5:2])
          4'h0: o_rdata <= {24'h0, ctrl_reg};
          4'h1: o_rdata <= {20'h0, instr_reg};
          4'h2: o_rdata <= {20'h0, oper_reg};
          4'h3: o_rdata <= {20'h0, acc_reg};
          4'h4: o_rdata <= {20'h0, mq_reg};
          4'h5: o_rdata <= {16'h0, major_reg, 1'b0, trapped_reg, o_io_wait_flag, repeat_reg, sync_reg,
                            skip_reg, flow_reg, link_reg, 2'h0, state_reg == AMX_IDLE, 1'b0};
          4'h6: o_rdata <= {8'h0, ret_reg, ma_reg};
          4'h7: o_rdata <= {16'h0, io_reg};
          default: o_rdata <= 32'h0000_0000;
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  assign o_io_pulse = io_reg.pulse;
  assign o_io_strobe = io_reg.strobe;
  assign o_io_opcode = io_reg.opcode;
  assign o_major = major_reg;
  assign o_skip = skip_reg;

  // zero count takes the short route to fetch
  a_zero_count_noop: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == AMX_DECODE && is_shift_w && count_w == 4'h0 && !trap_hit_w |=> state_reg == AMX_FETCH)
    else $error("zero count did not go to fetch");
  a_repeat_after_sync: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(sync_reg) |-> !repeat_reg [*8])
    else $error("repeat flag set before sync delay");
  a_count_down: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == AMX_RECYCLE |=> instr_reg[3:0] == $past(count_w) - 4'h1)
    else $error("count did not decrement");
  a_scale_sign: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == AMX_RECYCLE && is_scr_w |=> acc_reg[11] == $past(acc_reg[11]))
    else $error("scale changed sign");
  a_skip_polarity: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == AMX_DECODE && is_skip_w |=> skip_reg == $past(cond_w ^ ibit_w))
    else $error("skip flag wrong");
  a_io_three_pulses: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_io_wait_flag) |-> ##[599:599] o_io_wait_flag ##1 !o_io_wait_flag)
    else $error("io sequence length wrong");
  a_pulse_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    o_io_pulse[0] |-> o_io_wait_flag && o_io_opcode[0])
    else $error("pulse one without its gate bit");
  a_io_end_fetch: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_io_wait_flag) |-> state_reg == AMX_FETCH)
    else $error("io did not end into fetch");
  a_int_vector: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == AMX_FETCH && major_w == AMX_MS_INT |=>
    ma_reg == ($past(ctrl_reg[`AMX_CTRL_TRAP]) ? `AMX_TRAP_VEC : `AMX_INT_VEC))
    else $error("interrupt vector wrong");
  a_break_priority: assert property (@(posedge i_clk) disable iff (i_rst)
    state_reg == AMX_FETCH && ctrl_reg[`AMX_CTRL_TAPE_BRK] |=> major_reg == AMX_MS_TAPE)
    else $error("tape break lost priority");
endmodule : amx_exec
`default_nettype wire

// file: logic/amx_pkg.sv
// types for the alternate-mode execution block
`default_nettype none
package amx_pkg;
  typedef enum logic [5:0] {
    AMX_IDLE = 6'h01,
    AMX_DECODE = 6'h02,
    AMX_SYNC = 6'h04,
    AMX_RECYCLE = 6'h08,
    AMX_IO = 6'h10,
    AMX_FETCH = 6'h20
  } amx_state_e;
  typedef enum logic [3:0] {
    AMX_MS_FETCH = 4'h1,
    AMX_MS_TAPE = 4'h2,
    AMX_MS_DATA = 4'h4,
    AMX_MS_INT = 4'h8
  } amx_major_e;
  typedef struct packed {
    logic [2:0] pulse;
    logic strobe;
    logic [11:0] opcode;
  } amx_io_s;
endpackage : amx_pkg
`default_nettype wire

// file: logic/amx_regs.svh
// register offsets, field positions, reset values and timing counts for the alternate-mode execution block
`ifndef AMX_REGS_SVH
`define AMX_REGS_SVH
// register byte addresses
`define AMX_CTRL_ADDR 6'h00
`define AMX_INSTR_ADDR 6'h04
`define AMX_OPER_ADDR 6'h08
`define AMX_ACC_ADDR 6'h0C
`define AMX_MQ_ADDR 6'h10
`define AMX_STAT_ADDR 6'h14
`define AMX_MA_ADDR 6'h18
`define AMX_IO_ADDR 6'h1C
// control register fields
`define AMX_CTRL_GO 0
`define AMX_CTRL_TRAP 1
`define AMX_CTRL_TAPE_TRAP 2
`define AMX_CTRL_LINK 3
`define AMX_CTRL_FLOW 4
`define AMX_CTRL_TAPE_BRK 5
`define AMX_CTRL_DATA_BRK 6
`define AMX_CTRL_INT_REQ 7
`define AMX_CTRL_RESET 8'h00
// fixed vectors
`define AMX_INT_VEC 12'h020
`define AMX_TRAP_VEC 12'h060
// i/o pulse and shift sync timing in ns, and the cycle counts derived from it
`define AMX_CLK_NS 4
`define AMX_STROBE_NS 500
`define AMX_END_NS 200
`define AMX_RESTART_NS 100
`define AMX_SYNC_NS 50
`define AMX_STROBE_CYC ((`AMX_STROBE_NS + `AMX_CLK_NS - 1) / `AMX_CLK_NS)
`define AMX_END_CYC ((`AMX_END_NS + `AMX_CLK_NS - 1) / `AMX_CLK_NS)
`define AMX_RESTART_CYC ((`AMX_RESTART_NS + `AMX_CLK_NS - 1) / `AMX_CLK_NS)
`define AMX_SYNC_CYC ((`AMX_SYNC_NS + `AMX_CLK_NS - 1) / `AMX_CLK_NS)
`endif

// file: sim/alt_mode_shift_skip_iot_trap_tb_top.sv
// self-checking bench for the alternate-mode execution block
`include "amx_regs.svh"
`default_nettype none
module alt_mode_shift_skip_iot_trap_tb_top
  import amx_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'h0;
  logic i_rst = 1'h1;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, clr = 1'h0;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [11:0] lvl = 12'hA53, read_right_switches_op = 12'hA5C, read_left_switches_op = 12'h3B1, opcode, ext, op_seen, wait_cyc;
  logic [5:0] skip_sense_switch_op = 6'h29;
  logic awready, wready, bvalid, arready, rvalid, wait_f, skip, strobe;
  logic [1:0] bresp, rresp, resp;
  logic [2:0] pulse, seen;
  logic [3:0] major;
  amx_io_s io;
  int error_cnt = 0;
  int n_tests = 0;
  assign io = '{pulse: pulse, strobe: strobe, opcode: opcode};
  always #2 i_clk = ~i_clk;
  amx_exec amx_exec_i (.i_clk(i_clk), .i_rst(i_rst), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .i_ext_level(ext), .i_sense_sw(skip_sense_switch_op), .i_right_sw(read_right_switches_op), .i_left_sw(read_left_switches_op), .o_io_pulse(pulse),
    .o_io_strobe(strobe), .o_io_opcode(opcode), .o_io_wait_flag(wait_f), .o_major(major), .o_skip(skip));
  amx_periph_model amx_periph_model_i (.i_clk(i_clk), .i_rst(i_rst), .i_io(io), .i_io_wait_flag(wait_f),
    .i_clear(clr), .i_level_set(lvl), .o_ext_level(ext), .o_seen(seen), .o_op_seen(op_seen),
    .o_wait_cyc(wait_cyc));
  task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out
  // ready is sampled mid-cycle, where it equals its value at the next rising edge
  task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    @(posedge i_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (int k = 0; k < 100; k++) begin
      @(negedge i_clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      resp = bresp;
      @(posedge i_clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) break;
    end
    bready <= 1'h0;
  endtask : bus_wr
  task automatic bus_rd(input logic [5:0] a);
    logic ta, tr;
    @(posedge i_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (int k = 0; k < 100; k++) begin
      @(negedge i_clk);
      ta = arvalid && arready;
      tr = rvalid;
      rd = rdata;
      resp = rresp;
      @(posedge i_clk);
      if (ta) arvalid <= 1'h0;
      if (tr) break;
    end
    rready <= 1'h0;
  endtask : bus_rd
  task automatic run(input logic [11:0] ins, input logic [7:0] c);
    bus_wr(`AMX_INSTR_ADDR, {20'h0, ins});
    bus_wr(`AMX_CTRL_ADDR, {24'h0, c | 8'h01});
    rd = 32'h1;
    for (int k = 0; k < 300 && rd[0] !== 1'h0; k++) bus_rd(`AMX_CTRL_ADDR);
    rd = 32'h0;
    for (int k = 0; k < 300 && rd[1] !== 1'h1; k++) bus_rd(`AMX_STAT_ADDR);
  endtask : run
  task automatic sh(input logic [11:0] ins, input logic [11:0] ac, input logic [11:0] mq, input logic lk);
    logic [23:0] x;
    logic l;
    x = {ac, mq};
    l = lk;
    for (int i = 0; i < ins[3:0]; i++) begin
      if (ins[6:5] == 2'h2) x = {x[0], x[23:1]};
      else if (ins[6:5] == 2'h3) begin
        l = ins[4] ? x[12] : l;
        x = {x[23], x[23:1]};
      end else begin
        {x[23:12], l} = ins[4] ? {x[22:12], l, x[23]} : {x[22:12], x[23], l};
      end
    end
    bus_wr(`AMX_ACC_ADDR, {20'h0, ac});
    bus_wr(`AMX_MQ_ADDR, {20'h0, mq});
    run(ins, {4'h0, lk, 3'h0});
    bus_rd(`AMX_ACC_ADDR);
    chk("acc", x[23:12], rd[11:0]);
    bus_rd(`AMX_MQ_ADDR);
    chk("mq", x[11:0], rd[11:0]);
    bus_rd(`AMX_STAT_ADDR);
    chk("link", {11'h0, l}, {11'h0, rd[4]});
  endtask : sh
  task automatic sk(input logic [11:0] ins, input logic [11:0] ac, input logic [11:0] mq, input logic [7:0] c,
      input logic e);
    bus_wr(`AMX_ACC_ADDR, {20'h0, ac});
    bus_wr(`AMX_MQ_ADDR, {20'h0, mq});
    run(ins, c);
    bus_rd(`AMX_STAT_ADDR);
    chk("skip", {11'h0, e}, {11'h0, rd[6]});
    chk("skip pin", {11'h0, e}, {11'h0, skip});
  endtask : sk
  task automatic t_bus();
    bus_rd(6'h20);
    chk("rresp", 12'h002, {10'h0, resp});
    bus_wr(6'h24, 32'h0);
    chk("bresp", 12'h002, {10'h0, resp});
  endtask : t_bus
  task automatic t_shift();
    sh(12'h0C0, 12'h5A3, 12'h0F1, 1'h0);
    sh(12'h0C1, 12'h5A3, 12'h0F1, 1'h1);
    sh(12'h0CF, 12'h5A3, 12'h0F1, 1'h0);
    sh(12'h0E3, 12'h9A3, 12'h0F1, 1'h1);
    sh(12'h0F5, 12'h9A3, 12'h0F1, 1'h0);
    sh(12'h0A5, 12'h5A3, 12'h0F1, 1'h1);
    sh(12'h0BB, 12'h8A3, 12'h0F1, 1'h1);
  endtask : t_shift
  task automatic t_skip();
    sk(12'h12E, 12'h000, 12'h000, 8'h00, 1'h1);
    sk(12'h13E, 12'h000, 12'h000, 8'h00, 1'h0);
    sk(12'h129, 12'h7FF, 12'h000, 8'h00, 1'h1);
    sk(12'h129, 12'h800, 12'h000, 8'h00, 1'h0);
    sk(12'h139, 12'h800, 12'h000, 8'h00, 1'h1);
    sk(12'h128, 12'hFFF, 12'h000, 8'h00, 1'h1);
    sk(12'h128, 12'h000, 12'h000, 8'h00, 1'h1);
    sk(12'h128, 12'h001, 12'h000, 8'h00, 1'h0);
    sk(12'h12A, 12'h000, 12'h000, 8'h08, 1'h0);
    sk(12'h12A, 12'h000, 12'h000, 8'h00, 1'h1);
    sk(12'h12C, 12'h000, 12'h000, 8'h10, 1'h1);
    sk(12'h12C, 12'h000, 12'h000, 8'h00, 1'h0);
    sk(12'h12D, 12'h000, 12'hFFE, 8'h00, 1'h1);
    sk(12'h12D, 12'h000, 12'hFFF, 8'h00, 1'h0);
    for (int n = 0; n < 12; n++) sk(12'h100 | 12'(n), 12'h000, 12'h000, 8'h00, lvl[n]);
    for (int n = 0; n < 6; n++) sk(12'h120 | 12'(n), 12'h000, 12'h000, 8'h00, skip_sense_switch_op[n]);
  endtask : t_skip
  task automatic t_switch();
    run(12'h14E, 8'h00);
    bus_rd(`AMX_ACC_ADDR);
    chk("right switches", read_right_switches_op, rd[11:0]);
    run(12'h14F, 8'h00);
    bus_rd(`AMX_ACC_ADDR);
    chk("left switches", read_left_switches_op, rd[11:0]);
  endtask : t_switch
  task automatic t_iob();
    logic [11:0] ops [2] = '{12'h605, 12'h002};
    for (int i = 0; i < 2; i++) begin
      bus_wr(`AMX_OPER_ADDR, {20'h0, ops[i]});
      clr <= 1'h1;
      @(posedge i_clk);
      clr <= 1'h0;
      run(12'h140, 8'h00);
      chk("pulses", {9'h0, ops[i][2:0]}, {9'h0, seen});
      chk("io word", ops[i], op_seen);
      chk("io span", 12'h001, {11'h0, wait_cyc > 12'h253 && wait_cyc < 12'h25D});
      chk("wait flag", 12'h000, {11'h0, wait_f});
      chk("fetch", 12'h001, {8'h0, major});
    end
  endtask : t_iob
  task automatic t_trap();
    logic [11:0] ti [14] = '{12'h141, 12'h3C0, 12'h14D, 12'h14E, 12'h151, 12'h15D, 12'h160, 12'h17F,
      12'h1C0, 12'h1C0, 12'h1E0, 12'h3D0, 12'h3DF, 12'h141};
    logic [7:0] tc [14] = '{8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h02, 8'h06, 8'h02,
      8'h02, 8'h02, 8'h00};
    logic te [14] = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 1'h1, 1'h1, 1'h0};
    logic [11:0] m0, d0, d1;
    for (int i = 0; i < 14; i++) begin
      bus_rd(`AMX_MA_ADDR);
      m0 = rd[11:0];
      run(ti[i], tc[i]);
      bus_rd(`AMX_STAT_ADDR);
      chk("trapped", {11'h0, te[i]}, {11'h0, rd[10]});
      bus_rd(`AMX_MA_ADDR);
      if (te[i]) chk("trap vector", 12'h060, rd[11:0]);
      if (i == 0) d0 = rd[23:12] - m0;
      if (i == 1) d1 = rd[23:12] - m0;
    end
    chk("two word return", d0 + 12'h001, d1);
  endtask : t_trap
  task automatic t_int();
    logic [7:0] cs [5] = '{8'hE0, 8'hC0, 8'h80, 8'h82, 8'h00};
    logic [3:0] ms [5] = '{4'h2, 4'h4, 4'h8, 4'h8, 4'h1};
    for (int i = 0; i < 5; i++) begin
      // wait for idle so the vector is read after the fetch has loaded it
      run(12'h0C0, cs[i]);
      chk("major", {8'h0, ms[i]}, {8'h0, major});
      bus_rd(`AMX_MA_ADDR);
      if (i == 2 || i == 3) chk("int vector", i == 2 ? 12'h020 : 12'h060, rd[11:0]);
    end
  endtask : t_int
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'h0;
    t_bus();
    t_shift();
    t_skip();
    t_switch();
    t_iob();
    t_trap();
    t_int();
    close_out();
  end
  // whole run is far below this span; a hang ends here
  initial begin
    #300000;
    error_cnt++;
    close_out();
  end
endmodule : alt_mode_shift_skip_iot_trap_tb_top
`default_nettype wire

// file: sim/amx_periph_model.sv
// peripheral controller model on the programmed i/o bus
`default_nettype none
module amx_periph_model
  import amx_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // i/o bus from the block
  input wire amx_io_s i_io,
  input wire logic i_io_wait_flag,
  // bench control
  input wire logic i_clear,
  input wire logic [11:0] i_level_set,
  // levels and observations
  output logic [11:0] o_ext_level,
  output logic [2:0] o_seen,
  output logic [11:0] o_op_seen,
  output logic [11:0] o_wait_cyc
);
  timeunit 1ns;
  timeprecision 1ps;
  // levels are static, so no release pattern is needed
  assign o_ext_level = i_level_set;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_seen <= 3'h0;
      o_op_seen <= 12'h000;
      o_wait_cyc <= 12'h000;
    end else if (i_clear) begin
      o_seen <= 3'h0;
      o_op_seen <= 12'h000;
      o_wait_cyc <= 12'h000;
    end else begin
      o_seen <= o_seen | i_io.pulse;
      if (i_io.strobe) o_op_seen <= i_io.opcode;
      if (i_io_wait_flag) o_wait_cyc <= o_wait_cyc + 12'h001;
    end
  end
endmodule : amx_periph_model
`default_nettype wire
